// ### rtl/remappable_pin_select_matrix.sv
// What this block does
// - each peripheral input owns a pin selector
// - input selector fields are eight bits
// - input selector code n connects pin n, for n 1 to 181
// - six virtual pins numbered 176 to 181
// - outputs on virtual pins loop to inputs
// - each pin owns six-bit output selector
// - output code zero leaves default port function
// - no interlock between any selector fields
// - one pin many inputs, one output many pins
// - codes 1,2 route uart transmit, request-to-send
// - codes 5,6,7 route spi data, clock, select
// - codes 16,24,25 route compare, comparators
// - codes 45,46 route pwm sync outputs
// - listed peripheral inputs are all remappable
// - input and output selection fully independent
// - input code zero ties input low
// - remap beats port I/O, not analog or dedicated output
// - dedicated output overrides remapped output
`timescale 1ns/10ps
`include "pin_select_params.svh"
module remappable_pin_select_matrix #(
  parameter int NUM_PINS = 182 // pins 0..181, top six virtual
) (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [`NUM_PERIPH_IN*`IN_SEL_W-1:0] in_sel_wdata, // input selector write data
  input wire logic [`NUM_PERIPH_IN-1:0] in_sel_we, // per input selector write strobe
  input wire logic [NUM_PINS*`OUT_SEL_W-1:0] out_sel_wdata, // output selector write data
  input wire logic [NUM_PINS-1:0] out_sel_we, // per pin output selector write strobe
  input wire logic [NUM_PINS-1:0] pin_in, // pad input levels (virtual entries unused)
  input wire logic [NUM_PINS-1:0] pin_analog_en, // analog function active on pin
  input wire logic [NUM_PINS-1:0] pin_dedicated_out_en, // dedicated output active on pin
  input wire pin_select_pkg::periph_out_t periph_out, // peripheral output levels
  output logic [`NUM_PERIPH_IN*`IN_SEL_W-1:0] input_route_select_reg, // input selectors
  output logic [NUM_PINS*`OUT_SEL_W-1:0] output_route_select_reg, // output selectors
  output pin_select_pkg::periph_in_t periph_in, // routed peripheral inputs
  output logic [NUM_PINS-1:0] remap_out_active, // remapped output owns pin
  output logic [NUM_PINS-1:0] remap_out_data // remapped output level per pin
);
  localparam int NI = `NUM_PERIPH_IN;
  localparam int SW = `OUT_SEL_W;
  localparam int IW = `IN_SEL_W;

  // selector storage
  logic [IW-1:0] in_sel_r [NI]; // one field per peripheral input
  logic [SW-1:0] out_sel_r [NUM_PINS]; // one field per pin
  logic [NI-1:0] in_vec_nxt; // routed inputs, flat
  logic [NUM_PINS-1:0] act_nxt; // per pin remap active
  logic [NUM_PINS-1:0] dat_nxt; // per pin remap data
  logic [NUM_PINS-1:0] pin_level; // level seen on each pin, virtual included

  // decode a code into a peripheral output level, valid flag in bit 1
  function automatic logic [1:0] out_decode(input logic [SW-1:0] code,
                                            input pin_select_pkg::periph_out_t po);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      `OUT_UART_TX: r = {1'b1, po.uart_transmit_output};
      `OUT_UART_RTS: r = {1'b1, po.uart_request_to_send_output};
      `OUT_SPI_DATA: r = {1'b1, po.spi_data_output};
      `OUT_SPI_CLK: r = {1'b1, po.spi_clock_line};
      `OUT_SPI_SS: r = {1'b1, po.spi_slave_select_line};
      `OUT_COMPARE: r = {1'b1, po.compare_unit_output};
      `OUT_ACMP_ONE: r = {1'b1, po.analog_comparator_one_output};
      `OUT_ACMP_TWO: r = {1'b1, po.analog_comparator_two_output};
      `OUT_SYNC_PRI: r = {1'b1, po.pwm_primary_sync_output};
      `OUT_SYNC_SEC: r = {1'b1, po.pwm_secondary_sync_output};
      default: r = 2'h0; // null and unassigned codes
    endcase
    return r;
  endfunction

  // selector write path, each field independent of all others
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NI; i++) in_sel_r[i] <= `IN_SEL_GROUND;
      for (int p = 0; p < NUM_PINS; p++) out_sel_r[p] <= `OUT_NULL;
    end else begin
      // no cross-field checks of any kind
      for (int i = 0; i < NI; i++) begin
        if (in_sel_we[i]) in_sel_r[i] <= in_sel_wdata[i*IW +: IW];
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        if (out_sel_we[p]) out_sel_r[p] <= out_sel_wdata[p*SW +: SW];
      end
    end
  end

  // output mux per pin, dedicated output and analog take precedence
  always_comb begin
    logic [1:0] d;
    d = 2'h0;
    act_nxt = '0;
    dat_nxt = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      d = out_decode(out_sel_r[p], periph_out); // one output may feed many pins
      act_nxt[p] = d[1] & ~pin_dedicated_out_en[p] & ~pin_analog_en[p];
      dat_nxt[p] = d[0] & act_nxt[p];
    end
  end

  // pin levels: pads unless analog owns them, virtual pins carry routed output
  always_comb begin
    pin_level = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (p >= `VIRT_PIN_FIRST && p < `VIRT_PIN_FIRST + `VIRT_PIN_COUNT) begin
        pin_level[p] = dat_nxt[p]; // internal loopback
      end else begin
        pin_level[p] = pin_in[p] & ~pin_analog_en[p]; // analog disables digital
      end
    end
  end

  // input mux per peripheral input, code zero ties low
  always_comb begin
    in_vec_nxt = '0;
    for (int i = 0; i < NI; i++) begin
      // out of range codes read low; software keeps them valid
      if (in_sel_r[i] != `IN_SEL_GROUND && int'(in_sel_r[i]) < NUM_PINS) begin
        in_vec_nxt[NI-1-i] = pin_level[in_sel_r[i]];
      end
    end
  end

  // routed results and selector readback
  assign periph_in = pin_select_pkg::periph_in_t'(in_vec_nxt);
  assign remap_out_active = act_nxt;
  assign remap_out_data = dat_nxt;
  always_comb begin
    for (int i = 0; i < NI; i++) input_route_select_reg[i*IW +: IW] = in_sel_r[i];
    for (int p = 0; p < NUM_PINS; p++) output_route_select_reg[p*SW +: SW] = out_sel_r[p];
  end

  // assertions
  property p_null_idle;
    @(posedge sys_clk) disable iff (!reset_n)
      out_sel_r[0] == `OUT_NULL |-> !remap_out_active[0];
  endproperty
  a_null_idle: assert property (p_null_idle) else $error("null code drove pin");

  property p_uart_tx;
    @(posedge sys_clk) disable iff (!reset_n)
      (out_sel_r[1] == `OUT_UART_TX && !pin_dedicated_out_en[1] && !pin_analog_en[1])
      |-> remap_out_data[1] == periph_out.uart_transmit_output;
  endproperty
  a_uart_tx: assert property (p_uart_tx) else $error("uart tx not routed");

  property p_dedicated;
    @(posedge sys_clk) disable iff (!reset_n)
      pin_dedicated_out_en[2] |-> !remap_out_active[2];
  endproperty
  a_dedicated: assert property (p_dedicated) else $error("dedicated not overriding");

  property p_write_next;
    @(posedge sys_clk) disable iff (!reset_n)
      in_sel_we[0] |=> in_sel_r[0] == $past(in_sel_wdata[IW-1:0]);
  endproperty
  a_write_next: assert property (p_write_next) else $error("selector write late");

  property p_ground;
    @(posedge sys_clk) disable iff (!reset_n)
      in_sel_r[0] == `IN_SEL_GROUND |-> !periph_in.external_interrupt_one_input;
  endproperty
  a_ground: assert property (p_ground) else $error("ground code not low");

  property p_virtual;
    @(posedge sys_clk) disable iff (!reset_n)
      (in_sel_r[7] == 8'hb0 && out_sel_r[176] == `OUT_ACMP_ONE && !pin_analog_en[176]
       && !pin_dedicated_out_en[176])
      |-> periph_in.pwm_fault_inputs[7] == periph_out.analog_comparator_one_output;
  endproperty
  a_virtual: assert property (p_virtual) else $error("virtual loopback broken");

  property p_analog;
    @(posedge sys_clk) disable iff (!reset_n)
      pin_analog_en[3] |-> !remap_out_active[3];
  endproperty
  a_analog: assert property (p_analog) else $error("remap beat analog");

  property p_unassigned;
    @(posedge sys_clk) disable iff (!reset_n)
      out_sel_r[4] == 6'h03 |-> !remap_out_active[4];
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned code active");

  c_uart: cover property (@(posedge sys_clk) remap_out_active[1]);
  c_loop: cover property (@(posedge sys_clk) in_sel_r[7] == 8'hb0);
  c_write: cover property (@(posedge sys_clk) in_sel_we[0] ##2 in_sel_we[1]);
endmodule

// ### pkg/pin_select_params.svh
`ifndef PIN_SELECT_PARAMS_SVH
`define PIN_SELECT_PARAMS_SVH
// selector widths
`define IN_SEL_W 8
`define OUT_SEL_W 6
// input selector code that ties the peripheral input low
`define IN_SEL_GROUND 8'h00
// first virtual pin number and count of virtual pins
`define VIRT_PIN_FIRST 176
`define VIRT_PIN_COUNT 6
// output selector codes
`define OUT_NULL 6'h00
`define OUT_UART_TX 6'h01
`define OUT_UART_RTS 6'h02
`define OUT_SPI_DATA 6'h05
`define OUT_SPI_CLK 6'h06
`define OUT_SPI_SS 6'h07
`define OUT_COMPARE 6'h10
`define OUT_ACMP_ONE 6'h18
`define OUT_ACMP_TWO 6'h19
`define OUT_SYNC_PRI 6'h2d
`define OUT_SYNC_SEC 6'h2e
// number of remappable peripheral inputs
`define NUM_PERIPH_IN 22
`endif

// ### pkg/pin_select_pkg.sv
package pin_select_pkg;
  // peripheral outputs that can be routed to pins
  typedef struct packed {
    logic uart_transmit_output;
    logic uart_request_to_send_output;
    logic spi_data_output;
    logic spi_clock_line;
    logic spi_slave_select_line;
    logic compare_unit_output;
    logic analog_comparator_one_output;
    logic analog_comparator_two_output;
    logic pwm_primary_sync_output;
    logic pwm_secondary_sync_output;
  } periph_out_t;

  // peripheral inputs fed from pins, index order matches selector array
  typedef struct packed {
    logic external_interrupt_one_input;
    logic external_interrupt_two_input;
    logic timer_one_clock_input;
    logic timer_two_clock_input;
    logic timer_three_clock_input;
    logic capture_unit_input;
    logic compare_fault_input;
    logic [7:0] pwm_fault_inputs;
    logic uart_receive_input;
    logic uart_clear_to_send_input;
    logic spi_data_input;
    logic spi_clock_line;
    logic spi_slave_select_line;
    logic pwm_sync_input_one;
    logic pwm_sync_input_two;
  } periph_in_t;
endpackage

// ### testbench/periph_pad_model.sv
`timescale 1ns/10ps
// pads and peripheral outputs that change on every rising clock edge
module periph_pad_model (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // async reset, active low
  output pin_select_pkg::periph_out_t periph_out, // peripheral output levels
  output logic [181:0] pin_in // pad levels
);
  // moving pattern, so a stale or swapped route shows up quickly
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_out <= 10'h2_a5;
      pin_in <= {91{2'h2}};
    end else begin
      periph_out <= periph_out + 10'h1_3b;
      pin_in <= {pin_in[180:0], ~^pin_in[181:170]};
    end
  end
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
`include "pin_select_params.svh"
module tb;
  // kind, index, expected level, expected selector code
  typedef struct {logic [1:0] k; int i; logic e; logic [7:0] c;} note_t;
  logic sys_clk, reset_n;
  logic [175:0] in_sel_wdata;
  logic [21:0] in_sel_we;
  logic [1091:0] out_sel_wdata;
  logic [181:0] out_sel_we, pin_in, pin_analog_en, pin_dedicated_out_en, act, dat;
  pin_select_pkg::periph_out_t periph_out;
  pin_select_pkg::periph_in_t periph_in;
  logic [21:0] pin_vec;
  logic [175:0] rd_in; // input selector readback
  logic [1091:0] rd_out; // output selector readback
  logic [5:0] codes [10];
  logic [7:0] sel [22];
  note_t q [$];
  note_t n;
  int n_fail, n_tests, seed;
  assign pin_vec = periph_in;
  remappable_pin_select_matrix u_remappable_pin_select_matrix (.sys_clk(sys_clk),
    .reset_n(reset_n), .in_sel_wdata(in_sel_wdata), .in_sel_we(in_sel_we),
    .out_sel_wdata(out_sel_wdata), .out_sel_we(out_sel_we), .pin_in(pin_in),
    .pin_analog_en(pin_analog_en), .pin_dedicated_out_en(pin_dedicated_out_en),
    .periph_out(periph_out), .input_route_select_reg(rd_in), .output_route_select_reg(rd_out),
    .periph_in(periph_in), .remap_out_active(act), .remap_out_data(dat));
  periph_pad_model u_periph_pad_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .periph_out(periph_out), .pin_in(pin_in));
  // clock, 20 ns period
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic note(logic [1:0] k, int i, logic e);
    q.push_back('{k, i, e, 8'h00});
  endtask
  // selector readback note: index below 22 is an input field, else pin index plus 22
  task automatic note_sel(int i, logic [7:0] c);
    q.push_back('{2'h3, i, 1'b0, c});
  endtask
  // one selector write, visible one edge later
  task automatic wr_in(int f, logic [7:0] c);
    @(posedge sys_clk);
    in_sel_wdata[f*8+:8] <= c;
    in_sel_we[f] <= 1'b1;
    @(posedge sys_clk);
    in_sel_we[f] <= 1'b0;
    #5;
  endtask
  task automatic wr_out(int p, logic [5:0] c);
    @(posedge sys_clk);
    out_sel_wdata[p*6+:6] <= c;
    out_sel_we[p] <= 1'b1;
    @(posedge sys_clk);
    out_sel_we[p] <= 1'b0;
    #5;
  endtask
  task automatic cmp_in(int i, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD periph_in[%0d] expected %b seen %b", i, e, s);
    end
  endtask
  task automatic cmp_out(string nm, int p, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s[%0d] expected %b seen %b", nm, p, e, s);
    end
  endtask
  task automatic cmp_sel(int i, logic [7:0] e);
    logic [7:0] s;
    s = (i < 22) ? rd_in[i*8+:8] : {2'h0, rd_out[(i-22)*6+:6]};
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD selector[%0d] expected %h seen %h", i, e, s);
    end
  endtask
  // watcher: settled outputs compared with every queued note, oldest first
  always @(negedge sys_clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        2'h0: cmp_in(n.i, n.e, pin_vec[21-n.i]);
        2'h1: cmp_out("remap_out_active", n.i, n.e, act[n.i]);
        2'h2: cmp_out("remap_out_data", n.i, n.e, dat[n.i]);
        default: cmp_sel(n.i, n.c);
      endcase
    end
  end
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    codes = '{`OUT_UART_TX, `OUT_UART_RTS, `OUT_SPI_DATA, `OUT_SPI_CLK, `OUT_SPI_SS,
      `OUT_COMPARE, `OUT_ACMP_ONE, `OUT_ACMP_TWO, `OUT_SYNC_PRI, `OUT_SYNC_SEC};
    seed = 32'hfe15_251f;
    {in_sel_wdata, in_sel_we, out_sel_wdata, out_sel_we} = '0;
    {pin_analog_en, pin_dedicated_out_en} = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    #5;
    for (int i = 0; i < 22; i++) note(2'h0, i, 1'b0);
    for (int p = 0; p < 182; p++) note(2'h1, p, 1'b0);
    note_sel(0, 8'h00);
    note_sel(22 + 1, 8'h00);
    // every input field to a random real pin
    for (int f = 0; f < 22; f++) begin
      sel[f] = 8'h01 + 8'($unsigned($random(seed)) % 175);
      wr_in(f, sel[f]);
      note(2'h0, f, pin_in[sel[f]]);
      note_sel(f, sel[f]);
    end
    wr_in(3, sel[0]);
    note(2'h0, 0, pin_in[sel[0]]);
    note(2'h0, 3, pin_in[sel[0]]);
    wr_in(5, `IN_SEL_GROUND);
    note(2'h0, 5, 1'b0);
    // every output code on its own pin
    for (int k = 0; k < 10; k++) begin
      wr_out(k + 1, codes[k]);
      note(2'h1, k + 1, 1'b1);
      note(2'h2, k + 1, periph_out[9-k]);
      note_sel(22 + k + 1, {2'h0, codes[k]});
    end
    wr_out(20, 6'h03);
    note(2'h1, 20, 1'b0);
    wr_out(4, 6'h03);
    note(2'h1, 4, 1'b0);
    wr_out(1, `OUT_NULL);
    note(2'h1, 1, 1'b0);
    wr_out(30, `OUT_UART_RTS);
    note(2'h2, 30, periph_out[8]);
    note(2'h2, 2, periph_out[8]);
    // comparator looped to a fault input through a virtual pin
    wr_out(`VIRT_PIN_FIRST, `OUT_ACMP_ONE);
    wr_in(7, 8'hb0);
    note(2'h0, 7, periph_out[3]);
    @(posedge sys_clk);
    pin_dedicated_out_en[2] <= 1'b1;
    pin_analog_en[sel[15]] <= 1'b1;
    @(posedge sys_clk);
    #5;
    note(2'h1, 2, 1'b0);
    note(2'h0, 15, 1'b0);
    // analog on a pin that carries a remapped output
    @(posedge sys_clk);
    pin_analog_en[3] <= 1'b1;
    @(posedge sys_clk);
    #5;
    note(2'h1, 3, 1'b0);
    note(2'h2, 3, 1'b0);
    // mid-run reset returns every selector to null routing
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    #5;
    note(2'h1, 1, 1'b0);
    note(2'h0, 7, 1'b0);
    note_sel(7, 8'h00);
    note_sel(22 + 176, 8'h00);
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule
